// ==== eid_pkg.sv ====
// package of constants and types for the external interrupt debouncer
package eid_pkg;
  // ********************************************************
  // sizes
  // ********************************************************
  localparam int EID_PINS = 8;
  localparam int EID_CNT_W = 4;
  localparam int EID_PRESC_W = 3;
  localparam int EID_DIV_W = 8;

  // ********************************************************
  // register byte offsets
  // ********************************************************
  localparam logic [7:0] EID_OFF_CTRL = 8'h00;
  localparam logic [7:0] EID_OFF_DEBCFG = 8'h04;
  localparam logic [7:0] EID_OFF_STCNT = 8'h08;
  localparam logic [7:0] EID_OFF_ASYNC = 8'h0c;
  localparam logic [7:0] EID_OFF_SENSE = 8'h10;
  localparam logic [7:0] EID_OFF_FILTDEB = 8'h14;
  localparam logic [7:0] EID_OFF_FLAG = 8'h18;
  localparam logic [7:0] EID_OFF_MASK = 8'h1c;
  localparam logic [7:0] EID_OFF_DEBOUNCED_PIN_STATE = 8'h20;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int EID_CTRL_EN_BIT = 0;
  localparam int EID_CTRL_CLOCK_SELECT_BIT = 1;
  localparam int EID_DEBCFG_TICK_ON_A_BIT = 4;
  localparam int EID_ASYNC_NM_BIT = 8;
  localparam int EID_DEB_LSB = 0;
  localparam int EID_FILT_LSB = 8;
  localparam int EID_FLAG_NM_BIT = 8;

  // ********************************************************
  // reset values, thresholds and sense encodings
  // ********************************************************
  localparam logic [EID_PRESC_W-1:0] EID_PRESC_RST = 3'h0;
  localparam logic [15:0] EID_SENSE_RST = 16'h0000;
  localparam logic [EID_CNT_W-1:0] EID_THRESH_LOW = 4'h4;
  localparam logic [EID_CNT_W-1:0] EID_THRESH_HIGH = 4'h8;
  localparam logic [1:0] EID_SENSE_NONE = 2'h0;
  localparam logic [1:0] EID_SENSE_RISE = 2'h1;
  localparam logic [1:0] EID_SENSE_FALL = 2'h2;
  localparam logic [1:0] EID_SENSE_BOTH = 2'h3;

  typedef struct packed {
    logic [EID_DIV_W-1:0] cnt;
    logic tick;
  } eid_div_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic enable;
    logic clkSel;
    logic [EID_PRESC_W-1:0] presc;
    logic tick_on_a;
    logic [EID_PINS-1:0] stateCountSel;
    logic [EID_PINS-1:0] asyncSelect;
    logic nmAsync;
    logic [2*EID_PINS-1:0] senseSetting;
    logic [EID_PINS-1:0] debEn;
    logic [EID_PINS-1:0] glitchFilterEn;
    logic [EID_PINS:0] flag;
    logic [EID_PINS:0] mask;
    logic [EID_PINS-1:0] debounced_pin_state;
    logic [EID_PINS-1:0] s0;
    logic [EID_PINS-1:0] s1;
    logic [EID_PINS-1:0] s2;
    logic [EID_PINS-1:0] prevSamp;
    logic nm0;
    logic nm1;
    logic [EID_PINS-1:0][EID_CNT_W-1:0] cnt;
  } eid_state_t;
endpackage

// ==== eid_tick_div.sv ====
// prescaler that makes the low frequency debounce tick
`timescale 1ns/100ps
`default_nettype none
module eid_tick_div
  import eid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [EID_PRESC_W-1:0] presc,
  output logic tick
);
  eid_div_t st_ff;
  eid_div_t nxt_st;
  logic [EID_DIV_W-1:0] lastCnt;

  // tick period is 2^(presc+1) clocks
  always_comb begin
    nxt_st = st_ff;
    lastCnt = EID_DIV_W'((9'h002 << presc) - 9'h001);
    nxt_st.tick = 1'b0;
    if (!enable) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= lastCnt) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule
`default_nettype wire

// ==== eid_debouncer.sv ====
// external interrupt pin edge detection and debouncing with wishbone registers
// What this block does
// - sync edge mode: nonmask flag set when newest sample differs from prior one
// - async edge mode: pins set flags directly; no clock request once every pin and the nonmask pin are async and none debounces
// - each pin debounces synchronously or asynchronously per its async_select bit
// - debouncer runs on controller clock; prescaler makes a low frequency tick
// - debounce may be enabled only when sense is rise, fall or both
// - glitch filter cannot be enabled on a pin that debounces
// - sample every clock; check transitional edge only on ticks
// - bounce checked every clock if tick_on_a is 0, else only on ticks
// - transitional edge increments counter; bounce clears counter
// - sync threshold is 4 with state_count_sel 0, 8 with it 1
// - async threshold is always 4
// - counter reaching threshold validates edge and updates debounced pin state
// - flag set whenever a debouncing pin's debounced pin state changes, whatever its sense
// - debounced pin state readable in a register in both modes
`timescale 1ns/100ps
`default_nettype none
module eid_debouncer
  import eid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [7:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire logic [EID_PINS-1:0] extIrqPin,
  input wire logic nonmaskPin,
  output logic clockRequest,
  output logic irq
);
  eid_state_t st_ff;
  eid_state_t nxt_st;
  logic tick;
  logic wrStb;
  logic rdStb;
  logic [31:0] wMask;
  logic [31:0] wVal;
  logic [EID_PINS-1:0] senseOk;
  logic [EID_PINS-1:0] samp;
  logic [EID_PINS-1:0] edgeHit;
  logic [EID_PINS:0] setEv;
  logic [EID_CNT_W-1:0] thresh;
  logic [EID_CNT_W-1:0] cntInc;
  logic bounceChk;
  logic rise;
  logic fall;

  // ********************************************************
  // low frequency tick
  // ********************************************************
  eid_tick_div u_div (
    .mclk(mclk),
    .reset(reset),
    .enable(st_ff.enable),
    .presc(st_ff.presc),
    .tick(tick)
  );

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    nxt_st = st_ff;
    wrStb = wbCycI && wbStbI && wbWeI && !st_ff.ack;
    rdStb = wbCycI && wbStbI && !wbWeI && !st_ff.ack;
    wMask = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}}, {8{wbSelI[0]}}};
    wVal = '0;
    senseOk = '0;
    samp = '0;
    edgeHit = '0;
    setEv = '0;
    thresh = EID_THRESH_LOW;
    cntInc = '0;
    bounceChk = 1'b0;
    rise = 1'b0;
    fall = 1'b0;

    // pins are sampled on every clock
    nxt_st.s0 = extIrqPin;
    nxt_st.s1 = st_ff.s0;
    nxt_st.s2 = st_ff.s1;
    nxt_st.nm0 = nonmaskPin;
    nxt_st.nm1 = st_ff.nm0;

    // nonmask edge: sync compares two samples, async looks at the raw pin
    if (st_ff.nmAsync) begin
      setEv[EID_FLAG_NM_BIT] = nonmaskPin != st_ff.nm0;
    end else begin
      setEv[EID_FLAG_NM_BIT] = st_ff.nm0 != st_ff.nm1;
    end

    for (int i = 0; i < EID_PINS; i++) begin
      senseOk[i] = st_ff.senseSetting[2*i +: 2] != EID_SENSE_NONE;
      // majority of three rejects single clock glitches on filtered pins
      if (st_ff.glitchFilterEn[i]) begin
        samp[i] = (st_ff.s0[i] & st_ff.s1[i]) | (st_ff.s1[i] & st_ff.s2[i])
          | (st_ff.s0[i] & st_ff.s2[i]);
      end else begin
        samp[i] = st_ff.s0[i];
      end
      nxt_st.prevSamp[i] = samp[i];

      if (st_ff.debEn[i]) begin
        // async debouncing ignores state_count_sel
        if (st_ff.asyncSelect[i]) begin
          thresh = EID_THRESH_LOW;
        end else if (st_ff.stateCountSel[i]) begin
          thresh = EID_THRESH_HIGH;
        end else begin
          thresh = EID_THRESH_LOW;
        end
        cntInc = st_ff.cnt[i] + 4'h1;
        bounceChk = st_ff.tick_on_a ? tick : 1'b1;
        if (st_ff.s0[i] != st_ff.debounced_pin_state[i]) begin
          if (tick) begin
            if (cntInc >= thresh) begin
              nxt_st.debounced_pin_state[i] = st_ff.s0[i];
              nxt_st.cnt[i] = '0;
              setEv[i] = 1'b1;
            end else begin
              nxt_st.cnt[i] = cntInc;
            end
          end
        end else if (bounceChk) begin
          nxt_st.cnt[i] = '0;
        end
      end else begin
        nxt_st.cnt[i] = '0;
        nxt_st.debounced_pin_state[i] = samp[i];
        // async pins take their edge straight from the pin
        if (st_ff.asyncSelect[i]) begin
          rise = extIrqPin[i] && !st_ff.s0[i];
          fall = !extIrqPin[i] && st_ff.s0[i];
        end else begin
          rise = samp[i] && !st_ff.prevSamp[i];
          fall = !samp[i] && st_ff.prevSamp[i];
        end
        unique case (st_ff.senseSetting[2*i +: 2])
          EID_SENSE_RISE: edgeHit[i] = rise;
          EID_SENSE_FALL: edgeHit[i] = fall;
          EID_SENSE_BOTH: edgeHit[i] = rise || fall;
          EID_SENSE_NONE: edgeHit[i] = 1'b0;
        endcase
        setEv[i] = edgeHit[i];
      end
    end
    if (!st_ff.enable) begin
      setEv = '0;
    end

    // ********************************************************
    // register writes
    // ********************************************************
    nxt_st.ack = wbCycI && wbStbI && !st_ff.ack;
    if (wrStb) begin
      unique case (wbAdrI)
        EID_OFF_CTRL: begin
          wVal = ({30'h0, st_ff.clkSel, st_ff.enable} & ~wMask) | (wbDatI & wMask);
          nxt_st.enable = wVal[EID_CTRL_EN_BIT];
          nxt_st.clkSel = wVal[EID_CTRL_CLOCK_SELECT_BIT];
        end
        EID_OFF_DEBCFG: begin
          wVal = ({27'h0, st_ff.tick_on_a, 1'b0, st_ff.presc} & ~wMask) | (wbDatI & wMask);
          nxt_st.presc = wVal[EID_PRESC_W-1:0];
          nxt_st.tick_on_a = wVal[EID_DEBCFG_TICK_ON_A_BIT];
        end
        EID_OFF_STCNT: begin
          wVal = ({24'h0, st_ff.stateCountSel} & ~wMask) | (wbDatI & wMask);
          nxt_st.stateCountSel = wVal[EID_PINS-1:0];
        end
        EID_OFF_ASYNC: begin
          wVal = ({23'h0, st_ff.nmAsync, st_ff.asyncSelect} & ~wMask) | (wbDatI & wMask);
          nxt_st.asyncSelect = wVal[EID_PINS-1:0];
          nxt_st.nmAsync = wVal[EID_ASYNC_NM_BIT];
        end
        EID_OFF_SENSE: begin
          wVal = ({16'h0, st_ff.senseSetting} & ~wMask) | (wbDatI & wMask);
          nxt_st.senseSetting = wVal[2*EID_PINS-1:0];
          // a pin whose sense goes to none loses its debouncer
          for (int i = 0; i < EID_PINS; i++) begin
            if (wVal[2*i +: 2] == EID_SENSE_NONE) begin
              nxt_st.debEn[i] = 1'b0;
            end
          end
        end
        EID_OFF_FILTDEB: begin
          wVal = ({16'h0, st_ff.glitchFilterEn, st_ff.debEn} & ~wMask) | (wbDatI & wMask);
          nxt_st.debEn = wVal[EID_DEB_LSB +: EID_PINS] & senseOk;
          // debounce wins when both are asked for
          nxt_st.glitchFilterEn = wVal[EID_FILT_LSB +: EID_PINS]
            & ~(wVal[EID_DEB_LSB +: EID_PINS] & senseOk);
        end
        EID_OFF_MASK: begin
          wVal = ({23'h0, st_ff.mask} & ~wMask) | (wbDatI & wMask);
          nxt_st.mask = wVal[EID_PINS:0];
        end
        default: begin
          wVal = '0;
        end
      endcase
    end

    // flags are write-one-to-clear; a new event in the same cycle wins
    if (wrStb && wbAdrI == EID_OFF_FLAG) begin
      nxt_st.flag = (st_ff.flag & ~(wbDatI[EID_PINS:0] & wMask[EID_PINS:0])) | setEv;
    end else begin
      nxt_st.flag = st_ff.flag | setEv;
    end

    // ********************************************************
    // register reads
    // ********************************************************
    nxt_st.rdat = '0;
    if (rdStb) begin
      unique case (wbAdrI)
        EID_OFF_CTRL: nxt_st.rdat = {30'h0, st_ff.clkSel, st_ff.enable};
        EID_OFF_DEBCFG: nxt_st.rdat = {27'h0, st_ff.tick_on_a, 1'b0, st_ff.presc};
        EID_OFF_STCNT: nxt_st.rdat = {24'h0, st_ff.stateCountSel};
        EID_OFF_ASYNC: nxt_st.rdat = {23'h0, st_ff.nmAsync, st_ff.asyncSelect};
        EID_OFF_SENSE: nxt_st.rdat = {16'h0, st_ff.senseSetting};
        EID_OFF_FILTDEB: nxt_st.rdat = {16'h0, st_ff.glitchFilterEn, st_ff.debEn};
        EID_OFF_FLAG: nxt_st.rdat = {23'h0, st_ff.flag};
        EID_OFF_MASK: nxt_st.rdat = {23'h0, st_ff.mask};
        EID_OFF_DEBOUNCED_PIN_STATE: nxt_st.rdat = {24'h0, st_ff.debounced_pin_state};
        default: nxt_st.rdat = '0;
      endcase
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.presc <= EID_PRESC_RST;
      st_ff.senseSetting <= EID_SENSE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wbAckO = st_ff.ack;
  assign wbDatO = st_ff.rdat;
  assign irq = |(st_ff.flag & st_ff.mask);
  // clock is requested while enabled and some pin or the nonmask pin works synchronously or any pin debounces
  assign clockRequest = st_ff.enable && (!(&st_ff.asyncSelect) || !st_ff.nmAsync
    || (|st_ff.debEn));
endmodule
`default_nettype wire

// ==== eid_debouncer_sva.sv ====
// port assertions for the external interrupt debouncer
`timescale 1ns/100ps
`default_nettype none
module eid_debouncer_sva
  import eid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [7:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAckO,
  input wire logic [EID_PINS-1:0] extIrqPin,
  input wire logic nonmaskPin,
  input wire logic clockRequest,
  input wire logic irq
);
  // ********************************************************
  // bus and interrupt relations
  // ********************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_ack_follows: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wbAckO |=> !wbAckO)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wbAckO |-> $past(wbCycI && wbStbI))
    else $error("ack without request");
  a_rdat_idle: assert property (!wbAckO |-> wbDatO == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (wbAckO && !$past(wbWeI)
    && $past(wbAdrI) > EID_OFF_DEBOUNCED_PIN_STATE |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  a_debounced_pin_state_upper: assert property (wbAckO && !$past(wbWeI)
    && $past(wbAdrI) == EID_OFF_DEBOUNCED_PIN_STATE |-> wbDatO[31:EID_PINS] == '0)
    else $error("pin state upper bits set");
  a_flag_upper: assert property (wbAckO && !$past(wbWeI)
    && $past(wbAdrI) == EID_OFF_FLAG |-> wbDatO[31:EID_PINS+1] == '0)
    else $error("flag upper bits set");
  a_mask_quiet: assert property (wbAckO && $past(wbWeI) && $past(wbAdrI) == EID_OFF_MASK
    && $past(wbSelI[1:0]) == 2'h3 && $past(wbDatI[8:0]) == 9'h0 |-> !irq)
    else $error("irq high with mask cleared");
  // the request depends on settings only, so pin activity must never move it
  a_clkreq_reg: assert property ($changed(clockRequest) |-> wbAckO && $past(wbWeI))
    else $error("clock request moved without write");
  c_write: cover property (wbAckO && $past(wbWeI));
  c_irq: cover property ($rose(irq));
  c_debounced_pin_state: cover property (wbAckO && $past(wbAdrI) == EID_OFF_DEBOUNCED_PIN_STATE && wbDatO != 0);
endmodule
`default_nettype wire

// ==== eid_pin_model.sv ====
// board side pin model: clean levels with optional per-clock chatter
`timescale 1ns/100ps
`default_nettype none
module eid_pin_model
  import eid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [EID_PINS-1:0] level,
  input wire logic [EID_PINS-1:0] chatter,
  input wire logic nmLevel,
  output logic [EID_PINS-1:0] extIrqPin,
  output logic nonmaskPin
);
  logic phaseFf;
  // chatter flips a pin every clock, faster than any debounce tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phaseFf <= 1'b0;
    end else begin
      phaseFf <= ~phaseFf;
    end
  end
  assign extIrqPin = level ^ (chatter & {EID_PINS{phaseFf}});
  assign nonmaskPin = nmLevel;
endmodule
`default_nettype wire

// ==== tb_eid_debouncer.sv ====
// self-checking bench for the external interrupt debouncer
`timescale 1ns/100ps
`default_nettype none
module tb_eid_debouncer
  import eid_pkg::*;
;
  typedef struct packed {
    int pin; logic async; logic stc; logic tick_on_a; logic [1:0] sense; int early; int late;
  } eid_row_t;
  // early reads land before the threshold can be met, late ones well after
  localparam eid_row_t ROWS [3] = '{'{0, 1'b0, 1'b0, 1'b0, EID_SENSE_RISE, 3, 20},
    '{1, 1'b0, 1'b1, 1'b1, EID_SENSE_FALL, 9, 30}, '{2, 1'b1, 1'b1, 1'b0, EID_SENSE_BOTH, 3, 14}};
  logic mclk, reset, wbCycI, wbStbI, wbWeI, wbAckO, nonmaskPin, nmLevel, clockRequest, irq;
  logic [7:0] wbAdrI;
  logic [3:0] wbSelI;
  logic [31:0] wbDatI, wbDatO, rdData, senseVal, asyncVal, stcVal, debVal;
  logic [EID_PINS-1:0] extIrqPin, pinLevel, pinChatter;
  int err_total, samples_checked;
  eid_debouncer u_eid_debouncer (.mclk(mclk), .reset(reset), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAckO(wbAckO), .extIrqPin(extIrqPin), .nonmaskPin(nonmaskPin),
    .clockRequest(clockRequest), .irq(irq));
  eid_pin_model u_eid_pin_model (.mclk(mclk), .reset(reset), .level(pinLevel),
    .chatter(pinChatter), .nmLevel(nmLevel), .extIrqPin(extIrqPin), .nonmaskPin(nonmaskPin));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAckO !== 1'b1 && n < 20);
    rdData = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    if (wbAckO !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t bus answer never came", $time);
      final_report();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chkIrq(input logic e);
    #1;
    chk(irq, e);
  endtask
  initial begin
    int p;
    {reset, wbCycI, wbStbI, wbWeI, wbAdrI, wbDatI, nmLevel} = {1'b1, 44'h0};
    {pinLevel, pinChatter, senseVal, asyncVal, stcVal, debVal} = '0;
    wbSelI = 4'hf;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    chk(irq, 1'b0);
    chk(clockRequest, 1'b0);
    wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
    chk(rdData, 32'h0);
    nmLevel <= 1'b1;
    idle(5);
    wb(1'b0, EID_OFF_FLAG, 32'h0);
    chk(rdData, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rdData, 32'h0);
    wb(1'b1, EID_OFF_CTRL, 32'h1);
    chk(clockRequest, 1'b1);
    wb(1'b1, EID_OFF_MASK, 32'h1ff);
    for (int r = 0; r < 3; r++) begin
      p = ROWS[r].pin;
      senseVal[2*p +: 2] = ROWS[r].sense;
      asyncVal[p] = ROWS[r].async;
      stcVal[p] = ROWS[r].stc;
      debVal[p] = 1'b1;
      wb(1'b1, EID_OFF_SENSE, senseVal);
      wb(1'b1, EID_OFF_ASYNC, asyncVal);
      wb(1'b1, EID_OFF_STCNT, stcVal);
      wb(1'b1, EID_OFF_DEBCFG, {27'h0, ROWS[r].tick_on_a, 4'h0});
      wb(1'b1, EID_OFF_FILTDEB, debVal);
      pinLevel[p] <= 1'b1;
      idle(ROWS[r].early);
      wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
      chk(rdData[p], 1'b0);
      idle(ROWS[r].late);
      wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
      chk(rdData[p], 1'b1);
      wb(1'b0, EID_OFF_FLAG, 32'h0);
      chk(rdData[p], 1'b1);
      chk(irq, 1'b1);
      wb(1'b1, EID_OFF_FLAG, 32'h1 << p);
      wb(1'b0, EID_OFF_FLAG, 32'h0);
      chk(rdData, 32'h0);
      chk(irq, 1'b0);
    end
    senseVal[7:6] = EID_SENSE_BOTH;
    debVal[3] = 1'b1;
    wb(1'b1, EID_OFF_SENSE, senseVal);
    wb(1'b1, EID_OFF_FILTDEB, debVal);
    wb(1'b1, EID_OFF_DEBCFG, 32'h0);
    pinChatter[3] <= 1'b1;
    idle(40);
    wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
    chk(rdData[3], 1'b0);
    pinChatter[3] <= 1'b0;
    pinLevel[3] <= 1'b1;
    idle(20);
    wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
    chk(rdData[3], 1'b1);
    wb(1'b1, EID_OFF_FLAG, 32'h8);
    pinLevel[3] <= 1'b0;
    idle(20);
    wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
    chk(rdData[3], 1'b0);
    wb(1'b0, EID_OFF_FLAG, 32'h0);
    chk(rdData[3], 1'b1);
    wb(1'b1, EID_OFF_FILTDEB, debVal | 32'h10);
    wb(1'b0, EID_OFF_FILTDEB, 32'h0);
    chk(rdData[4], 1'b0);
    senseVal[9:8] = EID_SENSE_RISE;
    wb(1'b1, EID_OFF_SENSE, senseVal);
    wb(1'b1, EID_OFF_FILTDEB, debVal | 32'h1010);
    wb(1'b0, EID_OFF_FILTDEB, 32'h0);
    chk(rdData[4], 1'b1);
    chk(rdData[12], 1'b0);
    senseVal[11:10] = EID_SENSE_RISE;
    debVal[5:4] = 2'h3;
    wb(1'b1, EID_OFF_SENSE, senseVal);
    wb(1'b1, EID_OFF_FILTDEB, debVal);
    wb(1'b1, EID_OFF_DEBCFG, 32'h7);
    pinLevel[5] <= 1'b1;
    idle(100);
    wb(1'b0, EID_OFF_DEBOUNCED_PIN_STATE, 32'h0);
    chk(rdData[5], 1'b0);
    wb(1'b1, EID_OFF_FLAG, 32'h1ff);
    nmLevel <= 1'b0;
    idle(5);
    wb(1'b0, EID_OFF_FLAG, 32'h0);
    chk(rdData[8], 1'b1);
    wb(1'b1, EID_OFF_FLAG, 32'h100);
    asyncVal[8] = 1'b1;
    wb(1'b1, EID_OFF_ASYNC, asyncVal);
    nmLevel <= 1'b1;
    idle(3);
    wb(1'b0, EID_OFF_FLAG, 32'h0);
    chk(rdData[8], 1'b1);
    chkIrq(1'b1);
    wb(1'b1, EID_OFF_MASK, 32'h0);
    chkIrq(1'b0);
    wb(1'b1, EID_OFF_MASK, 32'h1ff);
    chkIrq(1'b1);
    wb(1'b1, EID_OFF_FLAG, 32'h1ff);
    chkIrq(1'b0);
    // mid-run reset must bring irq, the clock request and the control register back to zero
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    chk(irq, 1'b0);
    chk(clockRequest, 1'b0);
    wb(1'b0, EID_OFF_CTRL, 32'h0);
    chk(rdData, 32'h0);
    final_report();
  end
endmodule
bind eid_debouncer eid_debouncer_sva u_eid_debouncer_sva (.mclk(mclk), .reset(reset),
  .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
  .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .extIrqPin(extIrqPin),
  .nonmaskPin(nonmaskPin), .clockRequest(clockRequest), .irq(irq));
`default_nettype wire
